// ===== hw/watchdog_reload_bytes.sv
// Watchdog reload byte registers and 24-bit down counter.
// How it works
// - The refresh instruction copies the 24-bit reload value into the counter while the watchdog is enabled.
// - Upper byte gives bits 23..16, middle 15..8, lower 7..0.
// - Reload byte writes change the stored reload value, never the counter.
// - Reading any reload byte register returns the live counter.
// - Writes 55h then AAh to the control address unlock; control bits unchanged.
// - Upper, middle, lower written in order; any other write relocks.
// - First enable loads the reload value, then the counter decrements.
`timescale 1ns/100ps
module watchdog_reload_bytes
    import wdt_reload_pkg::*;
#(
    parameter int DIV_CYCLES = OSC_DIV_CYCLES
)
(
    // System.
    input wire logic clk_sys,
    input wire logic nrst,
    // Register port.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // Watchdog control.
    input wire logic wdt_enable,
    input wire logic watchdog_refresh_instruction,
    output logic [23:0] count,
    output logic timeout
);
    // ************************************************************
    // Parameter check
    // ************************************************************
    // The divider counts from zero to DIV_CYCLES - 1 in OSC_DIV_WIDTH bits.
    // A longer period would have its terminal count cut to OSC_DIV_WIDTH bits and tick early, so it is refused here.
    if (DIV_CYCLES < 1 || DIV_CYCLES > (1 << OSC_DIV_WIDTH))
    begin : g_bad_div_cycles
        $error("DIV_CYCLES out of range");
    end

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Joins the three reload bytes into one 24-bit word, upper byte on top.
    function automatic logic [23:0] join_bytes(input logic [7:0] upper, input logic [7:0] middle,
        input logic [7:0] lower);
        logic [23:0] word;
        word = 24'h000000;
        word[UPPER_LSB +: 8] = upper;
        word[MIDDLE_LSB +: 8] = middle;
        word[LOWER_LSB +: 8] = lower;
        return word;
    endfunction

    // True when the address names one of the three reload byte registers.
    function automatic logic is_reload_addr(input logic [11:0] addr);
        logic hit;
        hit = 1'b0;
        if (addr == ADDR_RELOAD_UPPER)
            hit = 1'b1;
        else if (addr == ADDR_RELOAD_MIDDLE)
            hit = 1'b1;
        else if (addr == ADDR_RELOAD_LOWER)
            hit = 1'b1;
        return hit;
    endfunction

    // Picks the counter byte that a read of the given address returns; any other address reads zero.
    function automatic logic [7:0] count_lane(input logic [11:0] addr, input logic [23:0] value);
        logic [7:0] lane;
        lane = 8'h00;
        if (addr == ADDR_RELOAD_UPPER)
            lane = value[UPPER_LSB +: 8];
        else if (addr == ADDR_RELOAD_MIDDLE)
            lane = value[MIDDLE_LSB +: 8];
        else if (addr == ADDR_RELOAD_LOWER)
            lane = value[LOWER_LSB +: 8];
        return lane;
    endfunction

    // ************************************************************
    // Unlock sequencer
    // ************************************************************
    // Every write goes to the sequencer, which grants at most one reload byte per step.
    // Reads are not forwarded, so polling the counter never breaks an unlock in progress.
    wdt_reload_if bus ();

    assign bus.wr_en = reg_wr;
    assign bus.addr = reg_addr;
    assign bus.wdata = reg_wdata;

    wdt_unlock_seq u_lock
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .bus(bus)
    );

    // ************************************************************
    // Reload bytes
    // ************************************************************
    logic [7:0] reload_upper_byte;
    logic [7:0] reload_middle_byte;
    logic [7:0] reload_lower_byte;
    wire logic [23:0] reload_value = join_bytes(reload_upper_byte, reload_middle_byte,
        reload_lower_byte);

    // Reload bytes only change under the unlock sequence; the counter is untouched.
    // A locked write, or a write to a byte out of turn, is dropped here without trace.
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            reload_upper_byte <= RESET_RELOAD_UPPER;
            reload_middle_byte <= RESET_RELOAD_MIDDLE;
            reload_lower_byte <= RESET_RELOAD_LOWER;
        end
        else
        begin
            if (bus.allow_upper)
                reload_upper_byte <= reg_wdata;
            if (bus.allow_middle)
                reload_middle_byte <= reg_wdata;
            if (bus.allow_lower)
                reload_lower_byte <= reg_wdata;
        end
    end

    // ************************************************************
    // Oscillator tick and counter
    // ************************************************************
    logic [OSC_DIV_WIDTH-1:0] div_cnt;
    logic osc_tick;
    logic enable_d;
    // The enable edge detector resets low, so an enable already high when reset lifts
    // still counts as a first enable and loads the reload value.
    wire logic first_enable = wdt_enable && !enable_d;
    // The divider stands in for the slow watchdog oscillator: one tick every DIV_CYCLES clocks.
    wire logic [OSC_DIV_WIDTH-1:0] div_last = OSC_DIV_WIDTH'(DIV_CYCLES - 1);
    wire logic div_wrap = div_cnt == div_last;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            div_cnt <= '0;
            osc_tick <= 1'b0;
        end
        else if (div_wrap)
        begin
            div_cnt <= '0;
            osc_tick <= 1'b1;
        end
        else
        begin
            div_cnt <= div_cnt + 1'b1;
            osc_tick <= 1'b0;
        end
    end

    // ************************************************************
    // Counter
    // ************************************************************
    // A load on enable or refresh wins over a decrement in the same cycle, so a refresh that
    // meets an oscillator tick never loses the reload.
    wire logic load_now = first_enable || (wdt_enable && watchdog_refresh_instruction);
    wire logic step_now = wdt_enable && osc_tick && !load_now;
    wire logic [23:0] count_less_one = count - 24'h000001;

    // After reaching zero the counter rolls over to all ones and keeps counting; it is not reloaded.
    wire logic [23:0] next_count = load_now ? reload_value
        : step_now ? count_less_one : count;
    // The time-out pulse marks the step from one to zero.
    wire logic next_timeout = step_now && count == 24'h000001;

    // Reset leaves the counter at zero and the enable edge detector low.
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            enable_d <= 1'b0;
            count <= 24'h000000;
            timeout <= 1'b0;
        end
        else
        begin
            enable_d <= wdt_enable;
            count <= next_count;
            timeout <= next_timeout;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Reads return the live counter, never the stored reload value, so software can watch it run.
    // The byte comes from the count before this edge's update, the value the read was issued against.
    wire logic read_hit = is_reload_addr(reg_addr);
    wire logic [7:0] next_rdata = count_lane(reg_addr, count);

    // Read data is zero outside a read so a stale count never lingers on the bus.
    // The hit flag tells a real count of zero apart from a read of an unmapped address.
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            reg_rdata <= 8'h00;
            reg_hit <= 1'b0;
        end
        else
        begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
            reg_hit <= reg_rd && read_hit;
        end
    end
endmodule // watchdog_reload_bytes

// ===== hw/wdt_reload_pkg.sv
// Constants shared by the watchdog reload register bank.
package wdt_reload_pkg;
    localparam logic [11:0] ADDR_CONTROL_PORT = 12'hFF0;
    localparam logic [11:0] ADDR_RELOAD_UPPER = 12'hFF1;
    localparam logic [11:0] ADDR_RELOAD_MIDDLE = 12'hFF2;
    localparam logic [11:0] ADDR_RELOAD_LOWER = 12'hFF3;
    localparam logic [7:0] RESET_RELOAD_UPPER = 8'h00;
    localparam logic [7:0] RESET_RELOAD_MIDDLE = 8'h04;
    localparam logic [7:0] RESET_RELOAD_LOWER = 8'h00;
    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
    localparam int UPPER_LSB = 16;
    localparam int MIDDLE_LSB = 8;
    localparam int LOWER_LSB = 0;
    localparam int COUNT_WIDTH = 24;
    localparam int OSC_FREQ_HZ = 10000;
    localparam int SYS_FREQ_HZ = 40000000;
    localparam int OSC_DIV_CYCLES = SYS_FREQ_HZ / OSC_FREQ_HZ;
    localparam int OSC_DIV_WIDTH = 12;

    typedef enum logic [2:0] {
        LOCK_IDLE,
        LOCK_GOT_FIRST,
        LOCK_OPEN_UPPER,
        LOCK_OPEN_MIDDLE,
        LOCK_OPEN_LOWER
    } lock_state_e;
endpackage

// ===== hw/wdt_reload_if.sv
// Interface carrying the unlock result between the lock sequencer and the register bank.
`timescale 1ns/100ps
interface wdt_reload_if;
    logic wr_en;
    logic [11:0] addr;
    logic [7:0] wdata;
    logic allow_upper;
    logic allow_middle;
    logic allow_lower;

    modport bank
    (
        output wr_en,
        output addr,
        output wdata,
        input allow_upper,
        input allow_middle,
        input allow_lower
    );
    modport lock
    (
        input wr_en,
        input addr,
        input wdata,
        output allow_upper,
        output allow_middle,
        output allow_lower
    );
endinterface

// ===== hw/wdt_unlock_seq.sv
// Lock state machine that gates writes to the reload bytes.
`timescale 1ns/100ps
module wdt_unlock_seq
    import wdt_reload_pkg::*;
(
    // System.
    input wire logic clk_sys,
    input wire logic nrst,
    // Bank side.
    wdt_reload_if.lock bus
);
    lock_state_e state;
    lock_state_e next_state;

    // ************************************************************
    // Sequence decoding
    // ************************************************************
    wire logic hit_ctrl = bus.addr == ADDR_CONTROL_PORT;
    wire logic hit_upper = bus.addr == ADDR_RELOAD_UPPER;
    wire logic hit_middle = bus.addr == ADDR_RELOAD_MIDDLE;
    wire logic hit_lower = bus.addr == ADDR_RELOAD_LOWER;

    // Any write that does not advance the sequence drops back to locked, except a repeated 55h, which stays in LOCK_GOT_FIRST.
    always_comb
    begin
        next_state = state;
        if (bus.wr_en)
        begin
            next_state = LOCK_IDLE;
            case (state)
                LOCK_IDLE:
                    if (hit_ctrl && bus.wdata == UNLOCK_FIRST)
                        next_state = LOCK_GOT_FIRST;
                LOCK_GOT_FIRST:
                    if (hit_ctrl && bus.wdata == UNLOCK_SECOND)
                        next_state = LOCK_OPEN_UPPER;
                    else if (hit_ctrl && bus.wdata == UNLOCK_FIRST)
                        next_state = LOCK_GOT_FIRST;
                LOCK_OPEN_UPPER:
                    if (hit_upper)
                        next_state = LOCK_OPEN_MIDDLE;
                LOCK_OPEN_MIDDLE:
                    if (hit_middle)
                        next_state = LOCK_OPEN_LOWER;
                default:
                    next_state = LOCK_IDLE;
            endcase
        end
    end

    assign bus.allow_upper = state == LOCK_OPEN_UPPER && hit_upper;
    assign bus.allow_middle = state == LOCK_OPEN_MIDDLE && hit_middle;
    assign bus.allow_lower = state == LOCK_OPEN_LOWER && hit_lower;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            state <= LOCK_IDLE;
        else
            state <= next_state;
    end
endmodule // wdt_unlock_seq

// ===== test/wdt_reload_sva.sv
// Port checks for the watchdog reload register bank.
`timescale 1ns/100ps
module wdt_reload_sva
    import wdt_reload_pkg::*;
#(
    parameter int DIV_CYCLES = OSC_DIV_CYCLES
)
(
    // System.
    input wire logic clk_sys,
    input wire logic nrst,
    // Register port.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_hit,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Counter.
    input wire logic wdt_enable,
    input wire logic watchdog_refresh_instruction,
    input wire logic timeout,
    input wire logic [23:0] count
);
    logic [23:0] count_d;
    always_ff @(posedge clk_sys)
        count_d <= count;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_read_upper: assert property (
        reg_rd && reg_addr == ADDR_RELOAD_UPPER |=> reg_hit && reg_rdata == count_d[23:16]) else $error("upper read");
    a_read_middle: assert property (
        reg_rd && reg_addr == ADDR_RELOAD_MIDDLE |=> reg_hit && reg_rdata == count_d[15:8]) else $error("middle read");
    a_read_lower: assert property (
        reg_rd && reg_addr == ADDR_RELOAD_LOWER |=> reg_hit && reg_rdata == count_d[7:0]) else $error("lower read");
    a_read_miss: assert property (
        reg_rd && !(reg_addr inside {[12'hFF1:12'hFF3]}) |=> !reg_hit && reg_rdata == 8'h00) else $error("miss read");
    a_write_silent: assert property (
        reg_wr && !reg_rd |=> !reg_hit && reg_rdata == 8'h00) else $error("write answered");
    a_count_frozen: assert property (
        !wdt_enable |=> count == count_d) else $error("count moved while disabled");
    a_count_step: assert property (
        wdt_enable && $past(wdt_enable) && !watchdog_refresh_instruction |=> count == count_d || count == count_d - 24'h1)
        else $error("count step wrong");
    a_load_floor: assert property (
        $rose(wdt_enable) || wdt_enable && watchdog_refresh_instruction |=> count >= 24'h4) else $error("load low");
    a_timeout_step: assert property (
        timeout |-> count == 24'h000000 && $past(count) == 24'h000001) else $error("time-out off the one to zero step");
    a_timeout_pulse: assert property (
        timeout |=> !timeout) else $error("time-out longer than one cycle");
    c_timeout: cover property (timeout);
    c_refresh: cover property (wdt_enable && watchdog_refresh_instruction);
    c_enable: cover property ($rose(wdt_enable));
    c_read: cover property (reg_rd && reg_addr == ADDR_RELOAD_LOWER);
endmodule // wdt_reload_sva
bind watchdog_reload_bytes wdt_reload_sva #(.DIV_CYCLES(DIV_CYCLES)) chk (.*);

// ===== test/wdt_cpu_model.sv
// Processor model: register bus cycles and the refresh pulse.
`timescale 1ns/100ps
module wdt_cpu_model
    import wdt_reload_pkg::*;
(
    // System.
    input wire logic clk_sys,
    // Register bus and refresh.
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic watchdog_refresh_instruction,
    output logic [11:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial {reg_wr, reg_rd, watchdog_refresh_instruction, reg_addr, reg_wdata} = '0;
    // Released address and data are inverted so a stale value is never mistaken for a held one.
    task automatic cycle(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, a, d};
        @(posedge clk_sys);
        #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
    endtask
    task automatic load(input logic [23:0] v);
        cycle(1, ADDR_CONTROL_PORT, UNLOCK_FIRST);
        cycle(1, ADDR_CONTROL_PORT, UNLOCK_SECOND);
        cycle(1, ADDR_RELOAD_UPPER, v[23:16]);
        cycle(1, ADDR_RELOAD_MIDDLE, v[15:8]);
        cycle(1, ADDR_RELOAD_LOWER, v[7:0]);
    endtask
    task automatic refresh();
        @(posedge clk_sys);
        #1 watchdog_refresh_instruction = 1;
        @(posedge clk_sys);
        #1 watchdog_refresh_instruction = 0;
    endtask
endmodule // wdt_cpu_model

// ===== test/test_watchdog_reload_bytes.sv
// Self-checking bench for the watchdog reload register bank.
`timescale 1ns/100ps
`define CHECK(got, want) begin samples_checked++; if ((got) !== (want)) begin fail_count++; \
    $display("wrong value at %0t: got %h want %h", $time, got, want); end end
module test_watchdog_reload_bytes;
    import wdt_reload_pkg::*;
    logic clk_sys = 0, nrst = 0, wdt_enable = 0, reg_wr, reg_rd, watchdog_refresh_instruction, reg_hit, timeout;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [23:0] count;
    int fail_count = 0, samples_checked = 0, cycles = 0, wait_cycles = 0;
    always #12.5 clk_sys = ~clk_sys;
    watchdog_reload_bytes #(.DIV_CYCLES(16)) dut (.*);
    wdt_cpu_model cpu (.*);
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fail_count++;
            end_sim();
        end
    end
    task automatic do_reset();
        @(posedge clk_sys);
        #1 nrst = 0;
        repeat (8) @(posedge clk_sys);
        #1 nrst = 1;
    endtask
    // Enable, refresh, then disable so the counter holds the loaded value for reading.
    task automatic reload_and_hold();
        @(posedge clk_sys);
        #1 wdt_enable = 1;
        cpu.refresh();
        wdt_enable = 0;
    endtask
    task automatic read_all(input logic [23:0] want);
        for (int i = 0; i < 3; i++)
        begin
            cpu.cycle(0, ADDR_RELOAD_UPPER + 12'(i), 8'h00);
            `CHECK({reg_hit, reg_rdata}, {1'b1, want[23 - 8 * i -: 8]})
        end
    endtask
    // ****************************************
    // Tests.
    // ****************************************
    initial
    begin
        do_reset();
        read_all(24'h000000);
        reload_and_hold();
        read_all({RESET_RELOAD_UPPER, RESET_RELOAD_MIDDLE, RESET_RELOAD_LOWER});
        $display("test reset_values done");
        cpu.load(24'h123456);
        read_all(24'h000400);
        reload_and_hold();
        read_all(24'h123456);
        $display("test unlock_load done");
        cpu.cycle(1, ADDR_RELOAD_LOWER, 8'h77);
        cpu.cycle(1, ADDR_CONTROL_PORT, UNLOCK_FIRST);
        cpu.cycle(1, ADDR_CONTROL_PORT, UNLOCK_SECOND);
        cpu.cycle(1, ADDR_RELOAD_UPPER, 8'hAB);
        cpu.cycle(1, ADDR_CONTROL_PORT, 8'h00);
        cpu.cycle(1, ADDR_RELOAD_MIDDLE, 8'hCD);
        reload_and_hold();
        read_all(24'hAB3456);
        cpu.cycle(0, 12'hFF5, 8'h00);
        `CHECK({reg_hit, reg_rdata}, 9'h000)
        $display("test broken_sequence done");
        do_reset();
        reload_and_hold();
        read_all(24'h000400);
        @(posedge clk_sys);
        #1 wdt_enable = 1;
        repeat (40) @(posedge clk_sys);
        #1;
        `CHECK(count inside {[24'h3FC:24'h3FE]}, 1'b1)
        $display("test count_down done");
        cpu.load(24'h000004);
        cpu.refresh();
        while (wait_cycles < 80 && timeout !== 1'b1)
        begin
            @(posedge clk_sys);
            #1 wait_cycles++;
        end
        `CHECK({timeout, count}, {1'b1, 24'h000000})
        `CHECK(wait_cycles inside {[49:64]}, 1'b1)
        @(posedge clk_sys);
        #1;
        `CHECK(timeout, 1'b0)
        repeat (16) @(posedge clk_sys);
        #1;
        `CHECK(count, 24'hFFFFFF)
        $display("test time_out done");
        end_sim();
    end
endmodule // test_watchdog_reload_bytes
